/* hw/gain_offset_stage.sv */
`timescale 1ns/1ps
module gain_offset_stage
   import speed_tracker_pkg::*;
(
   input  wire logic              sys_clk_i,
   input  wire logic              rst_i,
   input  wire logic              sample_valid_i,
   input  wire sample_t           field_sample_i,
   input  wire logic [GAIN_W-1:0] gain_i,
   input  wire peak_pair_s        peaks_i,
   input  wire logic              peak_update_i,
   output logic                   processed_valid_o,
   output sample_t                processed_differential_signal_o
);

   localparam int PROD_W = SPAN_W + GAIN_W + 1;
   localparam logic signed [PROD_W-1:0] SAT_HI =
      PROD_W'(2 ** (SAMPLE_W - 1) - 1);
   localparam logic signed [PROD_W-1:0] SAT_LO = -(SAT_HI + 1);

   sample_t                    offset_q;
   logic signed [SPAN_W-1:0]   diff;
   logic signed [PROD_W-1:0]   prod;
   logic signed [PROD_W-1:0]   scaled;
   logic signed [SPAN_W-1:0]   mid;

   always_comb begin
      diff   = SPAN_W'(field_sample_i) - SPAN_W'(offset_q);
      prod   = PROD_W'(diff) * $signed({1'b0, gain_i});
      scaled = prod >>> GAIN_FRAC;
      mid    = (SPAN_W'(peaks_i.high) + SPAN_W'(peaks_i.low)) >>> 1;
   end

   // The offset moves one count per peak update, so a noisy peak cannot
   // pull the baseline far; the cost is slow settling of large offsets.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         offset_q <= '0;
      end else if (peak_update_i) begin
         if (mid > OFS_DEADBAND && offset_q != {1'b0, {(SAMPLE_W-1){1'b1}}})
         begin
            offset_q <= offset_q + sample_t'(1);
         end else if (mid < -OFS_DEADBAND &&
                      offset_q != {1'b1, {(SAMPLE_W-1){1'b0}}}) begin
            offset_q <= offset_q - sample_t'(1);
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         processed_valid_o               <= 1'b0;
         processed_differential_signal_o <= '0;
      end else begin
         processed_valid_o <= sample_valid_i;
         if (sample_valid_i) begin
            if (scaled > SAT_HI) begin
               processed_differential_signal_o <= SAT_HI[SAMPLE_W-1:0];
            end else if (scaled < SAT_LO) begin
               processed_differential_signal_o <= SAT_LO[SAMPLE_W-1:0];
            end else begin
               processed_differential_signal_o <= scaled[SAMPLE_W-1:0];
            end
         end
      end
   end

endmodule

/* hw/zero_speed_edge_tracker.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Signal rising through the operate threshold drives the output low.
// - Signal falling to the release threshold drives the output high.
// - Thresholds follow tracked peaks; peaks move inward only a bounded step.
// - Each threshold comes from the peaks found at the last two edges.
// - Output stays in the high current state through the power-up interval.
// - Calibration on the first features, then running mode; accuracy may drop.
// - Gain calibration uses the first three high peaks at rising output edges; after a high-side start the first is at a falling edge.
// - No switchpoints until peak-to-peak exceeds the start hysteresis level.
// - Start threshold is operate when rising high, release when falling low.
// - Start hysteresis is checked only until the first threshold is set.
// - High-side start enables switching without toggling the high output.
// - High-side start: next release crossing drives the output low.
// - Low-side start at release drives the output low at once.
// - Undervoltage forces the output high regardless of the field.
// - Power-on gain is set from the measured peak-to-peak amplitude.
// - Running mode lowers gain gradually when the amplitude grows sharply.
// - Offset cancellation runs at each peak update, from the start threshold on; not in power-up.
// - Running mode blanks switching while the amplitude is below lockout.
// - A watchdog fully resets the logic when edge detection stops.
module zero_speed_edge_tracker
   import speed_tracker_pkg::*;
#(
   parameter int                WDOG_CYCLES     = WDOG_CYCLES_DFLT,
   parameter logic [SPAN_W-1:0] START_HYS_LEVEL = START_HYS_DFLT,
   parameter logic [SPAN_W-1:0] LOCKOUT_LEVEL   = LOCKOUT_DFLT
)
(
   input  wire logic              sys_clk_i,
   input  wire logic              rst_i,
   input  wire logic              sample_valid_i,
   input  wire sample_t           field_sample_i,
   input  wire logic              undervoltage_i,
   output logic                   high_current_output_state_o,
   output logic                   running_mode_o,
   output logic                   lockout_o,
   output logic [GAIN_W-1:0]      gain_o,
   output switchpoints_s          switchpoints_o
);

   localparam logic [15:0] PU_LAST = 16'(POWERUP_CYCLES - 1);
   localparam logic [31:0] WD_LAST = 32'(WDOG_CYCLES - 1);
   localparam logic [1:0]  CAL_LAST = 2'(CAL_PEAKS - 1);

   mode_e               mode_q;
   logic                wd_fire_q;
   logic                soft_rst;
   logic [15:0]         pu_cnt_q;
   logic [31:0]         wd_cnt_q;
   logic [1:0]          cal_cnt_q;
   logic [GAIN_W-1:0]   gain_q;
   peak_pair_s          peaks_q;
   sample_t             run_max_q;
   sample_t             run_min_q;
   logic                seek_rise_q;
   logic                first_fall_q;
   logic                out_low_q;
   logic                lockout_q;
   logic                peak_upd_q;
   logic                proc_valid;
   sample_t             proc;
   sample_t             new_max;
   sample_t             new_min;
   logic [SPAN_W-1:0]   start_span;
   logic [SPAN_W-1:0]   amp;
   logic                rise_edge;
   logic                fall_edge;
   logic                tracking;
   switchpoints_s       sw;
   sample_t             lim_high;
   sample_t             lim_low;
   logic signed [SPAN_W-1:0] span_s;
   logic signed [SPAN_W-1:0] mid_s;
   logic signed [SPAN_W-1:0] hys_s;

   // A watchdog expiry acts exactly like the external reset.
   assign soft_rst = rst_i | wd_fire_q;

   gain_offset_stage u_stage (
      .sys_clk_i                       (sys_clk_i),
      .rst_i                           (soft_rst),
      .sample_valid_i                  (sample_valid_i),
      .field_sample_i                  (field_sample_i),
      .gain_i                          (gain_q),
      .peaks_i                         (peaks_q),
      .peak_update_i                   (peak_upd_q),
      .processed_valid_o               (proc_valid),
      .processed_differential_signal_o (proc)
   );

   // Limit how far a freshly captured peak may pull inward.
   function automatic sample_t limit_inward(input sample_t old_pk,
                                            input sample_t new_pk,
                                            input logic    is_high);
      logic signed [SPAN_W-1:0] bound;
      bound = '0;
      if (is_high) begin
         bound = SPAN_W'(old_pk) - $signed(INWARD_STEP);
         if (SPAN_W'(new_pk) < bound) begin
            return bound[SAMPLE_W-1:0];
         end
      end else begin
         bound = SPAN_W'(old_pk) + $signed(INWARD_STEP);
         if (SPAN_W'(new_pk) > bound) begin
            return bound[SAMPLE_W-1:0];
         end
      end
      return new_pk;
   endfunction

   always_comb begin
      new_max    = (proc > run_max_q) ? proc : run_max_q;
      new_min    = (proc < run_min_q) ? proc : run_min_q;
      start_span = SPAN_W'(new_max) - SPAN_W'(new_min);
      tracking   = (mode_q == ST_CAL) || (mode_q == ST_RUN);
      rise_edge  = tracking && proc_valid && seek_rise_q &&
                   (proc > sw.operate_threshold);
      fall_edge  = tracking && proc_valid && !seek_rise_q &&
                   (proc < sw.release_threshold);
      lim_high   = limit_inward(peaks_q.high, run_max_q, 1'b1);
      lim_low    = limit_inward(peaks_q.low, run_min_q, 1'b0);
      amp        = fall_edge ? SPAN_W'(lim_high) - SPAN_W'(peaks_q.low)
                             : SPAN_W'(peaks_q.high) - SPAN_W'(lim_low);
   end

   // Switchpoints from the two most recent peaks: a midpoint with a
   // span-proportional hysteresis, so they scale with air gap.
   always_comb begin
      span_s = SPAN_W'(peaks_q.high) - SPAN_W'(peaks_q.low);
      mid_s  = SPAN_W'(peaks_q.low) + (span_s >>> 1);
      hys_s  = span_s >>> HYST_SHIFT;
      sw.operate_threshold = SAMPLE_W'(mid_s + hys_s);
      sw.release_threshold = SAMPLE_W'(mid_s - hys_s);
   end

   // Mode sequencing: power-up, start hysteresis, calibration, running.
   always_ff @(posedge sys_clk_i) begin
      if (soft_rst) begin
         mode_q <= ST_POWERUP;
      end else begin
         case (mode_q)
            ST_POWERUP: begin
               if (pu_cnt_q == PU_LAST) begin
                  mode_q <= ST_START;
               end
            end
            ST_START: begin
               if (proc_valid && start_span > START_HYS_LEVEL) begin
                  mode_q <= ST_CAL;
               end
            end
            ST_CAL: begin
               if (fall_edge && cal_cnt_q == CAL_LAST) begin
                  mode_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               mode_q <= ST_RUN;
            end
            default: begin
               mode_q <= ST_POWERUP;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (soft_rst) begin
         pu_cnt_q <= '0;
      end else if (mode_q == ST_POWERUP && pu_cnt_q != PU_LAST) begin
         pu_cnt_q <= pu_cnt_q + 16'h0001;
      end
   end

   // Watchdog: counts while edges are expected and restarts on each edge.
   always_ff @(posedge sys_clk_i) begin
      if (soft_rst) begin
         wd_cnt_q  <= '0;
         wd_fire_q <= 1'b0;
      end else if (!tracking || rise_edge || fall_edge) begin
         wd_cnt_q <= '0;
      end else if (wd_cnt_q == WD_LAST) begin
         wd_fire_q <= 1'b1;
      end else begin
         wd_cnt_q <= wd_cnt_q + 32'h0000_0001;
      end
   end

   // Running extremes since the last edge; in start mode since power-up.
   always_ff @(posedge sys_clk_i) begin
      if (soft_rst) begin
         run_max_q <= {1'b1, {(SAMPLE_W-1){1'b0}}};
         run_min_q <= {1'b0, {(SAMPLE_W-1){1'b1}}};
      end else if (rise_edge || fall_edge ||
                   (mode_q == ST_START && proc_valid &&
                    start_span > START_HYS_LEVEL)) begin
         run_max_q <= proc;
         run_min_q <= proc;
      end else if (proc_valid && mode_q != ST_POWERUP) begin
         run_max_q <= new_max;
         run_min_q <= new_min;
      end
   end

   // Peak capture and edge direction.
   always_ff @(posedge sys_clk_i) begin
      if (soft_rst) begin
         peaks_q      <= '0;
         seek_rise_q  <= 1'b0;
         first_fall_q <= 1'b0;
         peak_upd_q   <= 1'b0;
      end else begin
         peak_upd_q <= 1'b0;
         if (mode_q == ST_START && proc_valid &&
             start_span > START_HYS_LEVEL) begin
            peaks_q.high <= new_max;
            peaks_q.low  <= new_min;
            peak_upd_q   <= 1'b1;
            if (proc >= new_max) begin
               // Rising on the high side: operate is passed already.
               seek_rise_q  <= 1'b0;
               first_fall_q <= 1'b1;
            end else begin
               seek_rise_q  <= 1'b1;
            end
         end else if (rise_edge) begin
            peaks_q.low  <= lim_low;
            seek_rise_q  <= 1'b0;
            peak_upd_q   <= 1'b1;
         end else if (fall_edge) begin
            peaks_q.high <= lim_high;
            seek_rise_q  <= 1'b1;
            first_fall_q <= 1'b0;
            peak_upd_q   <= 1'b1;
         end
      end
   end

   // Gain: set during calibration, then only stepped down in running mode.
   always_ff @(posedge sys_clk_i) begin
      if (soft_rst) begin
         gain_q    <= GAIN_RESET;
         cal_cnt_q <= '0;
      end else if (fall_edge) begin
         if (mode_q == ST_CAL) begin
            cal_cnt_q <= cal_cnt_q + 2'b01;
            if (amp < (AGC_TARGET >> 1) && gain_q <= (GAIN_MAX >> 1)) begin
               gain_q <= gain_q << 1;
            end else if (amp < AGC_TARGET && gain_q != GAIN_MAX) begin
               gain_q <= gain_q + 8'h01;
            end else if (amp > AGC_HIGH && gain_q > (GAIN_MIN << 1)) begin
               gain_q <= gain_q >> 1;
            end
         end else if (mode_q == ST_RUN && amp > AGC_HIGH &&
                      gain_q > GAIN_MIN) begin
            // One count per high peak keeps the adjustment gradual.
            gain_q <= gain_q - 8'h01;
         end
      end
   end

   // Vibration lockout is judged once per edge in running mode.
   always_ff @(posedge sys_clk_i) begin
      if (soft_rst) begin
         lockout_q <= 1'b0;
      end else if (mode_q == ST_RUN && (rise_edge || fall_edge)) begin
         lockout_q <= (amp < LOCKOUT_LEVEL);
      end else if (mode_q != ST_RUN) begin
         lockout_q <= 1'b0;
      end
   end

   // Logical output state; true means the low current state.
   always_ff @(posedge sys_clk_i) begin
      if (soft_rst) begin
         out_low_q <= 1'b0;
      end else if (mode_q == ST_START && proc_valid &&
                   start_span > START_HYS_LEVEL) begin
         out_low_q <= (proc < new_max);
      end else if (rise_edge && !lockout_q) begin
         out_low_q <= 1'b1;
      end else if (fall_edge && first_fall_q) begin
         out_low_q <= 1'b1;
      end else if (fall_edge && !lockout_q) begin
         out_low_q <= 1'b0;
      end
   end

   // Registered pins. Undervoltage overrides everything, even mid-frame.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         high_current_output_state_o <= 1'b1;
      end else if (undervoltage_i || wd_fire_q) begin
         high_current_output_state_o <= 1'b1;
      end else if (mode_q == ST_POWERUP) begin
         high_current_output_state_o <= 1'b1;
      end else begin
         high_current_output_state_o <= !out_low_q;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (soft_rst) begin
         running_mode_o <= 1'b0;
         lockout_o      <= 1'b0;
         gain_o         <= GAIN_RESET;
         switchpoints_o <= '0;
      end else begin
         running_mode_o <= (mode_q == ST_RUN);
         lockout_o      <= lockout_q;
         gain_o         <= gain_q;
         switchpoints_o <= sw;
      end
   end

endmodule

/* shared/speed_tracker_pkg.sv */
package speed_tracker_pkg;

   // Datapath widths.
   localparam int SAMPLE_W = 12;
   localparam int GAIN_W   = 8;
   localparam int SPAN_W   = SAMPLE_W + 1;

   // Gain is unsigned fixed point with GAIN_FRAC fraction bits.
   localparam int                GAIN_FRAC  = 4;
   localparam logic [GAIN_W-1:0] GAIN_RESET = 8'h10;
   localparam logic [GAIN_W-1:0] GAIN_MIN   = 8'h01;
   localparam logic [GAIN_W-1:0] GAIN_MAX   = 8'hff;

   // Timing: the clock period and the power-up interval in ns.
   localparam int CLK_PERIOD_NS   = 20;
   localparam int POWERUP_TIME_NS = 20000;
   localparam int POWERUP_CYCLES  =
      (POWERUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WDOG_TIME_MS    = 500;
   localparam int WDOG_CYCLES_DFLT = WDOG_TIME_MS * (1000000 / CLK_PERIOD_NS);

   // Number of high peaks used for the initial gain calibration.
   localparam int CAL_PEAKS = 3;

   // Amplitude levels in processed-signal counts.
   localparam logic [SPAN_W-1:0] START_HYS_DFLT = 13'h0c0;
   localparam logic [SPAN_W-1:0] LOCKOUT_DFLT   = 13'h100;
   localparam logic [SPAN_W-1:0] AGC_TARGET     = 13'h600;
   localparam logic [SPAN_W-1:0] AGC_HIGH       = 13'he00;

   // Largest inward step of a tracked peak per signal edge.
   localparam logic [SPAN_W-1:0] INWARD_STEP = 13'h040;
   // Switchpoints sit at the midpoint plus or minus span >> HYST_SHIFT.
   localparam int HYST_SHIFT = 3;
   // Offset correction ignores midpoint errors inside this band.
   localparam logic signed [SPAN_W-1:0] OFS_DEADBAND = 13'sh008;

   typedef logic signed [SAMPLE_W-1:0] sample_t;

   typedef struct packed {
      sample_t high;
      sample_t low;
   } peak_pair_s;

   typedef struct packed {
      sample_t operate_threshold;
      sample_t release_threshold;
   } switchpoints_s;

   typedef enum {
      ST_POWERUP,
      ST_START,
      ST_CAL,
      ST_RUN
   } mode_e;

endpackage

/* testbench/loop_current_monitor.sv */
`timescale 1ns/1ps
module loop_current_monitor #(
   parameter int LOW_MIN_UA  = 5000,
   parameter int LOW_MAX_UA  = 8000,
   parameter int HIGH_MIN_UA = 12000,
   parameter int HIGH_MAX_UA = 16000
)
(
   input  wire logic   sys_clk_i,
   input  wire logic   rst_i,
   input  wire logic   high_current_output_state_i,
   output logic        fault_o,
   output logic [15:0] fall_cnt_o
);
   int   loop_ua;
   logic state_q;

   // An ideal regulator is assumed, so only an unknown pin reads as a fault.
   always_comb begin
      loop_ua = (high_current_output_state_i === 1'b1) ? 14000 :
                (high_current_output_state_i === 1'b0) ? 6500 : 0;
   end

   always_ff @(posedge sys_clk_i) begin
      state_q <= high_current_output_state_i;
      if (rst_i) begin
         fault_o    <= 1'b0;
         fall_cnt_o <= '0;
      end else begin
         if (loop_ua > HIGH_MAX_UA || loop_ua < LOW_MIN_UA ||
             (loop_ua > LOW_MAX_UA && loop_ua < HIGH_MIN_UA)) begin
            fault_o <= 1'b1;
         end
         if (state_q === 1'b1 && high_current_output_state_i === 1'b0) begin
            fall_cnt_o <= fall_cnt_o + 16'h0001;
         end
      end
   end
endmodule

/* testbench/zero_speed_edge_tracker_checker.sv */
`timescale 1ns/1ps
module zero_speed_edge_tracker_checker
   import speed_tracker_pkg::*;
(
   input wire logic              sys_clk_i,
   input wire logic              rst_i,
   input wire logic              sample_valid_i,
   input wire sample_t           field_sample_i,
   input wire logic              undervoltage_i,
   input wire logic              high_current_output_state_o,
   input wire logic              running_mode_o,
   input wire logic              lockout_o,
   input wire logic [GAIN_W-1:0] gain_o,
   input wire switchpoints_s     switchpoints_o
);
   // Cycles since reset, saturating so the power-up window is known.
   logic [10:0] since_rst_q;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         since_rst_q <= '0;
      end else if (since_rst_q < 11'(POWERUP_CYCLES)) begin
         since_rst_q <= since_rst_q + 11'h001;
      end
   end

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   reset_values_a: assert property ($past(rst_i) |->
      high_current_output_state_o && !running_mode_o && !lockout_o
      && gain_o == GAIN_RESET && switchpoints_o == '0)
      else $error("outputs not at reset values");
   powerup_high_a: assert property (since_rst_q < 11'(POWERUP_CYCLES)
      |-> high_current_output_state_o && !running_mode_o)
      else $error("output left high state during power-up");
   powerup_nopts_a: assert property (since_rst_q < 11'(POWERUP_CYCLES)
      |-> switchpoints_o == '0)
      else $error("switchpoints computed during power-up");
   uv_forces_high_a: assert property (undervoltage_i
      |=> high_current_output_state_o)
      else $error("output low under undervoltage");
   gain_step_down_a: assert property (running_mode_o && $past(running_mode_o)
      |-> gain_o <= $past(gain_o)
      && {1'b0, gain_o} + 9'h001 >= {1'b0, $past(gain_o)})
      else $error("running gain moved by more than one step");
   lockout_run_a: assert property (lockout_o |-> running_mode_o)
      else $error("lockout outside running mode");
   lockout_freeze_a: assert property ((lockout_o && !undervoltage_i)[*4]
      |-> $stable(high_current_output_state_o))
      else $error("output switched during lockout");
   wdog_rearm_a: assert property ($fell(running_mode_o)
      |-> high_current_output_state_o && gain_o == GAIN_RESET && !lockout_o)
      else $error("leaving running mode did not re-arm");
   thresh_order_a: assert property (switchpoints_o.operate_threshold
      >= switchpoints_o.release_threshold)
      else $error("operate threshold below release threshold");
   lockout_seen_c: cover property (lockout_o);
endmodule

/* testbench/zero_speed_edge_tracker_test.sv */
`timescale 1ns/1ps
module zero_speed_edge_tracker_test;
   import speed_tracker_pkg::*;
   localparam int WDOG  = 200;
   localparam int NROWS = 5;
   typedef struct {
      int   amp;
      int   periods;
      logic uv;
      logic exp_run;
      logic exp_fall;
   } row_s;
   row_s              rows [NROWS];
   logic [GAIN_W-1:0] gain_at [NROWS];
   logic              out_early [NROWS];
   logic              sys_clk_i, rst_i, sample_valid_i, undervoltage_i;
   sample_t           field_sample_i;
   logic              high_out, run, lock, fault;
   logic [GAIN_W-1:0] gain;
   switchpoints_s     sp;
   logic [15:0]       falls, falls0;
   int                err_total, n_tests, cycles;

   zero_speed_edge_tracker #(.WDOG_CYCLES(WDOG)) i_zero_speed_edge_tracker (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .sample_valid_i(sample_valid_i),
      .field_sample_i(field_sample_i), .undervoltage_i(undervoltage_i),
      .high_current_output_state_o(high_out), .running_mode_o(run),
      .lockout_o(lock), .gain_o(gain), .switchpoints_o(sp));

   loop_current_monitor i_loop_current_monitor (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .high_current_output_state_i(high_out), .fault_o(fault),
      .fall_cnt_o(falls));

   task automatic check(input string what, input logic [15:0] exp,
                        input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Triangle wave of 64 samples per period, starting at the low peak.
   task automatic run_row(input int r);
      int v;
      for (int n = 0; n < rows[r].periods * 64; n++) begin
         @(negedge sys_clk_i);
         v = n % 64;
         v = (v < 32) ? -rows[r].amp + v * rows[r].amp / 16
                      : rows[r].amp - (v - 32) * rows[r].amp / 16;
         field_sample_i = sample_t'(v);
         undervoltage_i = rows[r].uv;
         if (n == 8) begin
            out_early[r] = high_out;
         end
      end
   endtask

   initial begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end

   always @(posedge sys_clk_i) begin
      cycles++;
      // About 4,540 cycles are needed; the rest is margin.
      if (cycles == 8000) begin
         err_total++;
         report_and_stop();
      end
   end

   initial begin
      rst_i          = 1'b1;
      sample_valid_i = 1'b1;
      field_sample_i = '0;
      undervoltage_i = 1'b0;
      // Small swing, one period, the rest of calibration, undervoltage, big.
      rows[0] = '{32'h040, 4, 1'b0, 1'b0, 1'b0};
      rows[1] = '{32'h280, 1, 1'b0, 1'b0, 1'b1};
      rows[2] = '{32'h280, 5, 1'b0, 1'b1, 1'b1};
      rows[3] = '{32'h280, 2, 1'b1, 1'b1, 1'b0};
      rows[4] = '{32'h7f0, 4, 1'b0, 1'b1, 1'b1};
      repeat (5) @(negedge sys_clk_i);
      rst_i = 1'b0;
      @(negedge sys_clk_i);
      check("reset out", 16'h1, 16'(high_out));
      check("reset gain", 16'(GAIN_RESET), 16'(gain));
      repeat (POWERUP_CYCLES + 10) @(negedge sys_clk_i);
      check("powerup out", 16'h1, 16'(high_out));
      for (int r = 0; r < NROWS; r++) begin
         falls0 = falls;
         run_row(r);
         gain_at[r] = gain;
         check("running", 16'(rows[r].exp_run), 16'(run));
         check("falls", 16'(rows[r].exp_fall), 16'(falls != falls0));
         if (rows[r].uv) begin
            check("uv out", 16'h1, 16'(high_out));
         end
      end
      check("no start", 16'h1, 16'(out_early[0]));
      check("low start", 16'h0, 16'(out_early[1]));
      check("cal gain", 16'h1, 16'(gain_at[2] > GAIN_RESET));
      check("gain down", 16'h1, 16'(gain_at[4] < gain_at[3]));
      check("gain gradual", 16'h1, 16'(gain_at[4] + 4 >= gain_at[3]));
      check("op above", 16'h1, 16'(sp.operate_threshold > 0));
      check("rel below", 16'h1, 16'(sp.release_threshold < 0));
      // A slowly shrinking swing keeps the tracked peaks crossing until
      // the amplitude at each edge falls below the lockout level.
      rows[4].periods = 1;
      for (int a = 32'h7c0; a >= 32'h30; a -= 32'h40) begin
         rows[4].amp = a;
         run_row(4);
      end
      rows[4].amp = 32'h030;
      repeat (2) run_row(4);
      check("lockout", 16'h1, 16'(lock));
      falls0 = falls;
      repeat (2) run_row(4);
      check("lock falls", 16'h0, 16'(falls != falls0));
      check("lock run", 16'h1, 16'(run));
      field_sample_i = '0;
      repeat (WDOG + 60) @(negedge sys_clk_i);
      check("wdog run", 16'h0, 16'(run));
      check("wdog out", 16'h1, 16'(high_out));
      check("wdog gain", 16'(GAIN_RESET), 16'(gain));
      check("loop fault", 16'h0, 16'(fault));
      report_and_stop();
   end
endmodule

bind zero_speed_edge_tracker zero_speed_edge_tracker_checker
   i_zero_speed_edge_tracker_checker (
   .sys_clk_i(sys_clk_i), .rst_i(rst_i), .sample_valid_i(sample_valid_i),
   .field_sample_i(field_sample_i), .undervoltage_i(undervoltage_i),
   .high_current_output_state_o(high_current_output_state_o),
   .running_mode_o(running_mode_o), .lockout_o(lockout_o),
   .gain_o(gain_o), .switchpoints_o(switchpoints_o));
